//--- hdl/wprs_top.sv
`timescale 1ns/10ps
module wprs_top #(
   parameter int POR_CYC = wprs_pkg::POR_DONE_CYC,
   parameter int SETTLE_CYC = wprs_pkg::SYNTH_SETTLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic chip_enable_reset_n_i,
   input wire logic sd_clk_i,
   input wire logic sd_cmd_i,
   input wire logic sd_d1_i,
   input wire logic sd_d2_i,
   input wire logic bus_4bit_i,
   input wire logic [1:0] speed_mode_i,
   input wire logic irq_req_i,
   input wire logic read_wait_req_i,
   input wire logic oob_irq_en_i,
   input wire logic clk_force_i,
   input wire logic full_speed_req_i,
   output logic sd_d1_o,
   output logic sd_d1_oe_o,
   output logic sd_d2_o,
   output logic sd_d2_oe_o,
   output logic host_wake_out_o,
   output logic xtal_en_o,
   output logic synth_en_o,
   output logic subsys_pwr_en_o,
   output logic blocks_rst_n_o,
   output logic full_speed_o,
   output logic sd_clk_gate_en_o,
   output logic high_speed_o
);
   //////////////////////////////////////////////////////////////////////////////
   wprs_sync_if sy ();
   logic [2:0] st;
   logic xt, sy_en, stable;
   // undriven pin assumed pulled high outside, filtered here
   wprs_sync #(.FILTER_CYC(wprs_pkg::CE_FILTER_CYC)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .chip_enable_reset_n_i(chip_enable_reset_n_i),
      .sd_clk_i(sd_clk_i),
      .sd_cmd_i(sd_cmd_i),
      .sy(sy)
   );
   wprs_seq #(.POR_CYC(POR_CYC), .XTAL_CYC(wprs_pkg::XTAL_START_CYC),
      .SETTLE_CYC(SETTLE_CYC)) u_seq (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .sy(sy),
      .state_o(st),
      .xtal_en_o(xt),
      .synth_en_o(sy_en),
      .clocks_stable_o(stable)
   );
   //////////////////////////////////////////////////////////////////////////////
   logic sd_d1_q, sd_d1_d, d1oe_q, d1oe_d, sd_d2_q, sd_d2_d, d2oe_q, d2oe_d;
   logic wake_q, wake_d, xt_q, synth_q, pwr_q, brst_q, brst_d, fs_q, fs_d;
   logic gate_q, gate_d, hs_q, hs_d;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sd_d1_q <= 1'b1;
         d1oe_q <= 1'b0;
         sd_d2_q <= 1'b1;
         d2oe_q <= 1'b0;
         wake_q <= 1'b0;
         xt_q <= 1'b0;
         synth_q <= 1'b0;
         pwr_q <= 1'b0;
         brst_q <= 1'b0;
         fs_q <= 1'b0;
         gate_q <= 1'b0;
         hs_q <= 1'b0;
      end else begin
         sd_d1_q <= sd_d1_d;
         d1oe_q <= d1oe_d;
         sd_d2_q <= sd_d2_d;
         d2oe_q <= d2oe_d;
         wake_q <= wake_d;
         xt_q <= xt;
         synth_q <= sy_en;
         pwr_q <= stable;
         brst_q <= brst_d;
         fs_q <= fs_d;
         gate_q <= gate_d;
         hs_q <= hs_d;
      end
   end
   always_comb begin
      // resets released only after clocks stable
      brst_d = stable;
      // crystal clock until host asks for full speed
      fs_d = stable & (fs_q | full_speed_req_i);
      // 50 MHz class modes flagged for the interface timing
      hs_d = (speed_mode_i == wprs_pkg::SPEED_HS) || (speed_mode_i == wprs_pkg::SPEED_SDR25);
      // in-band interrupt on line 1, low active, four-line only
      d1oe_d = stable & bus_4bit_i & ~oob_irq_en_i & irq_req_i;
      sd_d1_d = 1'b0;
      // read wait drives line 2 low in four-line mode
      d2oe_d = stable & bus_4bit_i & read_wait_req_i;
      sd_d2_d = 1'b0;
      // out-of-band wake while sdio clock is stopped
      wake_d = stable & oob_irq_en_i & irq_req_i;
      // clock gate runs unless stopped; internal force wins
      gate_d = stable & (~oob_irq_en_i | clk_force_i);
   end
   assign sd_d1_o = sd_d1_q;
   assign sd_d1_oe_o = d1oe_q;
   assign sd_d2_o = sd_d2_q;
   assign sd_d2_oe_o = d2oe_q;
   assign host_wake_out_o = wake_q;
   assign xtal_en_o = xt_q;
   assign synth_en_o = synth_q;
   assign subsys_pwr_en_o = pwr_q;
   assign blocks_rst_n_o = brst_q;
   assign full_speed_o = fs_q;
   assign sd_clk_gate_en_o = gate_q;
   assign high_speed_o = hs_q;
endmodule

//--- hdl/wprs_pkg.sv
// What this block does
// - chip enable is reset control, undriven reads high via pull-up
// - enable held low keeps device off; a low pulse of at least CE_FILTER_CYC (8) clocks restarts it
// - internal power-on reset done within reset_low_min_time plus 2.5 ms
// - after reset run from crystal; host may load synthesizer setup first
// - after release stay off, subsystems unpowered, modules held in reset
// - on host communication start crystal first, then synthesizer
// - release internal block resets automatically once all clocks stable
// - sdio supports one-line and four-line data widths
// - default 25 MHz, high speed 50 MHz, sdr12 and sdr25 supported
// - in four-line mode data line 1 carries the interrupt
// - in four-line mode data line 2 carries read wait
// - sdio clock may stop while interrupt goes to a gpio pin
// - host wake output asks host to turn sdio back on
// - internal logic may force the gated sdio clocks on
package wprs_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int RESET_LOW_MIN_TIME_US = 500;
   localparam int RESET_LOW_MIN_CYC = (RESET_LOW_MIN_TIME_US * (CLK_HZ / 1000000));
   localparam int POR_EXTRA_US = 2500;
   localparam int POR_DONE_CYC = ((RESET_LOW_MIN_TIME_US + POR_EXTRA_US) * (CLK_HZ / 1000000));
   localparam int SYNTH_SETTLE_US = 100;
   localparam int SYNTH_SETTLE_CYC = (SYNTH_SETTLE_US * (CLK_HZ / 1000000));
   localparam int XTAL_START_CYC = 64;
   localparam int CE_FILTER_CYC = 8;
   localparam int SDIO_MAX_MHZ = 50;
   localparam int SDIO_HS_MHZ = 50;
   localparam int SDIO_DS_MHZ = 25;
   localparam logic [1:0] SPEED_DS = 2'h0;
   localparam logic [1:0] SPEED_HS = 2'h1;
   localparam logic [1:0] SPEED_SDR12 = 2'h2;
   localparam logic [1:0] SPEED_SDR25 = 2'h3;
   localparam logic [1:0] PWR_RESET_VAL = 2'h0;
   typedef enum logic [2:0] {
      PS_HELD, PS_POR, PS_OFF, PS_XTAL, PS_SYNTH, PS_RUN
   } wprs_state_t;
endpackage

//--- hdl/wprs_sync_if.sv
`timescale 1ns/10ps
interface wprs_sync_if;
   logic ce_n;
   logic sd_clk;
   logic sd_cmd;
   logic sd_clk_rise;
   logic host_comm;
   modport src (output ce_n, output sd_clk, output sd_cmd, output sd_clk_rise, output host_comm);
   modport dst (input ce_n, input sd_clk, input sd_cmd, input sd_clk_rise, input host_comm);
endinterface

//--- hdl/wprs_sync.sv
`timescale 1ns/10ps
module wprs_sync #(
   parameter int FILTER_CYC = 8
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic chip_enable_reset_n_i,
   input wire logic sd_clk_i,
   input wire logic sd_cmd_i,
   wprs_sync_if.src sy
);
   logic [2:0] s1_q, s2_q;
   logic sd_clk_d1_q;
   logic ce_filt_q, ce_filt_d;
   logic [7:0] cnt_q, cnt_d;
   logic comm_q, comm_d;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // enable high, clock idle low, command idle high: no false edge
         s1_q <= 3'h5;
         s2_q <= 3'h5;
         sd_clk_d1_q <= 1'b0;
         ce_filt_q <= 1'b1;
         cnt_q <= 8'h00;
         comm_q <= 1'b0;
      end else begin
         s1_q <= {chip_enable_reset_n_i, sd_clk_i, sd_cmd_i};
         s2_q <= s1_q;
         sd_clk_d1_q <= s2_q[1];
         ce_filt_q <= ce_filt_d;
         cnt_q <= cnt_d;
         comm_q <= comm_d;
      end
   end
   always_comb begin
      ce_filt_d = ce_filt_q;
      cnt_d = 8'h00;
      // level must hold for the filter width before it is taken
      if (s2_q[2] != ce_filt_q) begin
         cnt_d = cnt_q + 8'h01;
         if (cnt_q >= 8'(FILTER_CYC - 1)) begin
            ce_filt_d = s2_q[2];
            cnt_d = 8'h00;
         end
      end
      // start bit on command line marks host communication
      comm_d = s2_q[1] & ~sd_clk_d1_q & ~s2_q[0];
   end
   assign sy.ce_n = ce_filt_q;
   assign sy.sd_clk = s2_q[1];
   assign sy.sd_cmd = s2_q[0];
   assign sy.sd_clk_rise = s2_q[1] & ~sd_clk_d1_q;
   assign sy.host_comm = comm_q;
endmodule

//--- hdl/wprs_seq.sv
`timescale 1ns/10ps
module wprs_seq #(
   parameter int POR_CYC = wprs_pkg::POR_DONE_CYC,
   parameter int XTAL_CYC = wprs_pkg::XTAL_START_CYC,
   parameter int SETTLE_CYC = wprs_pkg::SYNTH_SETTLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   wprs_sync_if.dst sy,
   output logic [2:0] state_o,
   output logic xtal_en_o,
   output logic synth_en_o,
   output logic clocks_stable_o
);
   wprs_pkg::wprs_state_t st_q, st_d;
   logic [17:0] cnt_q, cnt_d;
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= wprs_pkg::PS_HELD;
         cnt_q <= 18'h00000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 18'h00001;
      case (st_q)
         wprs_pkg::PS_HELD: begin
            cnt_d = 18'h00000;
            if (sy.ce_n) begin
               st_d = wprs_pkg::PS_POR;
            end
         end
         wprs_pkg::PS_POR: begin
            // power-on reset finishes within the bound
            if (cnt_q >= 18'(POR_CYC - 1)) begin
               st_d = wprs_pkg::PS_OFF;
               cnt_d = 18'h00000;
            end
         end
         wprs_pkg::PS_OFF: begin
            // wait for the host, everything off
            cnt_d = 18'h00000;
            if (sy.host_comm) begin
               st_d = wprs_pkg::PS_XTAL;
            end
         end
         wprs_pkg::PS_XTAL: begin
            // crystal first, synthesizer after
            if (cnt_q >= 18'(XTAL_CYC - 1)) begin
               st_d = wprs_pkg::PS_SYNTH;
               cnt_d = 18'h00000;
            end
         end
         wprs_pkg::PS_SYNTH: begin
            if (cnt_q >= 18'(SETTLE_CYC - 1)) begin
               st_d = wprs_pkg::PS_RUN;
               cnt_d = 18'h00000;
            end
         end
         wprs_pkg::PS_RUN: begin
            cnt_d = 18'h00000;
         end
         default: begin
            st_d = wprs_pkg::PS_HELD;
            cnt_d = 18'h00000;
         end
      endcase
      // low level on enable restarts from scratch
      if (!sy.ce_n) begin
         st_d = wprs_pkg::PS_HELD;
         cnt_d = 18'h00000;
      end
   end
   assign state_o = 3'(st_q);
   assign xtal_en_o = (st_q == wprs_pkg::PS_XTAL) || (st_q == wprs_pkg::PS_SYNTH) ||
                      (st_q == wprs_pkg::PS_RUN);
   assign synth_en_o = (st_q == wprs_pkg::PS_SYNTH) || (st_q == wprs_pkg::PS_RUN);
   assign clocks_stable_o = (st_q == wprs_pkg::PS_RUN);
endmodule

//--- sim/wprs_assertions.sv
`timescale 1ns/10ps
module wprs_assertions (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic chip_enable_reset_n_i,
   input wire logic bus_4bit_i,
   input wire logic irq_req_i,
   input wire logic read_wait_req_i,
   input wire logic oob_irq_en_i,
   input wire logic clk_force_i,
   input logic sd_d1_oe_o,
   input logic sd_d2_oe_o,
   input logic host_wake_out_o,
   input logic xtal_en_o,
   input logic synth_en_o,
   input logic subsys_pwr_en_o,
   input logic blocks_rst_n_o,
   input logic sd_clk_gate_en_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_glitch;
      blocks_rst_n_o && chip_enable_reset_n_i ##1 !chip_enable_reset_n_i [*3] ##1 chip_enable_reset_n_i;
   endsequence
   property p_xfirst; $rose(xtal_en_o) |-> !synth_en_o [*8]; endproperty
   a_xfirst: assert property (p_xfirst) else $error("synth on with crystal");
   property p_rel; blocks_rst_n_o |-> subsys_pwr_en_o && synth_en_o && $past(synth_en_o, 16); endproperty
   a_rel: assert property (p_rel) else $error("blocks released early");
   property p_glitch; s_glitch |-> blocks_rst_n_o [*8]; endproperty
   a_glitch: assert property (p_glitch) else $error("glitch caused reset");
   property p_d1; (bus_4bit_i && irq_req_i && !oob_irq_en_i && blocks_rst_n_o) [*3] |-> sd_d1_oe_o; endproperty
   a_d1: assert property (p_d1) else $error("no interrupt on data line 1");
   property p_line1; !bus_4bit_i [*3] |-> !sd_d1_oe_o && !sd_d2_oe_o; endproperty
   a_line1: assert property (p_line1) else $error("data line driven in one-line mode");
   property p_d2; (bus_4bit_i && read_wait_req_i && blocks_rst_n_o) [*3] |-> sd_d2_oe_o; endproperty
   a_d2: assert property (p_d2) else $error("no read wait on data line 2");
   property p_wake; (oob_irq_en_i && irq_req_i && blocks_rst_n_o) [*3] |-> host_wake_out_o && !sd_d1_oe_o; endproperty
   a_wake: assert property (p_wake) else $error("wake not rerouted");
   property p_gate; (clk_force_i && blocks_rst_n_o) [*3] |-> sd_clk_gate_en_o; endproperty
   a_gate: assert property (p_gate) else $error("clock force ignored");
endmodule
bind wprs_top wprs_assertions u_chk (.ref_clk_i, .rstn_i, .chip_enable_reset_n_i, .bus_4bit_i,
   .irq_req_i, .read_wait_req_i, .oob_irq_en_i, .clk_force_i, .sd_d1_oe_o, .sd_d2_oe_o,
   .host_wake_out_o, .xtal_en_o, .synth_en_o, .subsys_pwr_en_o, .blocks_rst_n_o,
   .sd_clk_gate_en_o);

//--- sim/wprs_host_model.sv
`timescale 1ns/10ps
module wprs_host_model (
   output wire logic ce_n_o,
   output logic sd_clk_o,
   output logic sd_cmd_o
);
   logic ce_q = 1'b0;
   logic ce_drv = 1'b1;
   assign ce_n_o = ce_drv ? ce_q : 1'bz;
   initial begin
      sd_clk_o = 1'b0;
      sd_cmd_o = 1'b1;
   end
   task automatic set_ce(input logic v, input logic drv);
      ce_q = v;
      ce_drv = drv;
   endtask
   // start bit then one high bit, clock still outside
   task automatic send_cmd();
      for (int i = 0; i < 2; i++) begin
         sd_cmd_o = (i != 0);
         #160 sd_clk_o = 1'b1;
         #160 sd_clk_o = 1'b0;
      end
   endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam int POR = 50;
   localparam int SET = 20;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   tri1 ce_n;
   logic sd_clk, sd_cmd, d1, d1oe, d2, d2oe, wake, xtal, synth, pwr, brn, fs, gate, hs;
   logic bus4 = 1'b0, irq = 1'b0, rw = 1'b0, oob = 1'b0, frc = 1'b0, fsr = 1'b0;
   logic [1:0] spd = 2'h0;
   int fails = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   wprs_host_model u_host (.ce_n_o(ce_n), .sd_clk_o(sd_clk), .sd_cmd_o(sd_cmd));
   wprs_top #(.POR_CYC(POR), .SETTLE_CYC(SET)) u_dut (.ref_clk_i(clk), .rstn_i(rstn),
      .chip_enable_reset_n_i(ce_n), .sd_clk_i(sd_clk), .sd_cmd_i(sd_cmd),
      .sd_d1_i(d1oe ? d1 : 1'b1), .sd_d2_i(d2oe ? d2 : 1'b1), .bus_4bit_i(bus4),
      .speed_mode_i(spd), .irq_req_i(irq), .read_wait_req_i(rw), .oob_irq_en_i(oob),
      .clk_force_i(frc), .full_speed_req_i(fsr), .sd_d1_o(d1), .sd_d1_oe_o(d1oe),
      .sd_d2_o(d2), .sd_d2_oe_o(d2oe), .host_wake_out_o(wake), .xtal_en_o(xtal),
      .synth_en_o(synth), .subsys_pwr_en_o(pwr), .blocks_rst_n_o(brn), .full_speed_o(fs),
      .sd_clk_gate_en_o(gate), .high_speed_o(hs));
   task automatic chk(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wait_on(input int idx, input int lim);
      int n;
      logic [3:0] v;
      n = 0;
      v = {fs, brn, synth, xtal};
      while (v[idx] !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
         v = {fs, brn, synth, xtal};
      end
      if (n >= lim) begin
         fails++;
         $display("wrong value wait %0d expected 1 seen %b", idx, v[idx]);
      end
   endtask
   task automatic t_power;
      #(wprs_pkg::RESET_LOW_MIN_TIME_US * 1000);
      @(negedge clk);
      u_host.set_ce(1'b1, 1'b0);
      u_host.send_cmd();
      repeat (POR) @(negedge clk);
      chk("crystal", 1'b0, xtal);
      chk("block reset", 1'b0, brn);
      chk("power", 1'b0, pwr);
      u_host.send_cmd();
      chk("crystal", 1'b1, xtal);
      chk("synth", 1'b0, synth);
      wait_on(1, 90);
      chk("synth", 1'b1, synth);
      chk("block reset", 1'b0, brn);
      wait_on(2, SET + 10);
      chk("block reset", 1'b1, brn);
      chk("power", 1'b1, pwr);
   endtask
   task automatic t_full;
      chk("full speed", 1'b0, fs);
      repeat (SET) @(negedge clk);
      fsr = 1'b1;
      @(negedge clk);
      fsr = 1'b0;
      wait_on(3, 8);
      chk("full speed", 1'b1, fs);
   endtask
   task automatic t_lines;
      for (int i = 0; i < 4; i++) begin
         bus4 = i[0];
         irq = i[1];
         rw = i[1];
         repeat (4) @(negedge clk);
         chk("line 1 drive", i[0] & i[1], d1oe);
         chk("line 2 drive", i[0] & i[1], d2oe);
         chk("line 1 level", 1'b0, d1);
         chk("line 2 level", 1'b0, d2);
      end
   endtask
   task automatic t_oob;
      oob = 1'b1;
      repeat (4) @(negedge clk);
      chk("wake", 1'b1, wake);
      chk("line 1 drive", 1'b0, d1oe);
      chk("clock gate", 1'b0, gate);
      frc = 1'b1;
      repeat (4) @(negedge clk);
      chk("clock gate", 1'b1, gate);
   endtask
   task automatic t_speed;
      for (int m = 0; m < 4; m++) begin
         spd = 2'(m);
         repeat (4) @(negedge clk);
         chk("high speed", spd[0], hs);
      end
   endtask
   task automatic t_glitch;
      u_host.set_ce(1'b0, 1'b1);
      repeat (3) @(negedge clk);
      u_host.set_ce(1'b1, 1'b1);
      repeat (12) @(negedge clk);
      chk("block reset", 1'b1, brn);
      u_host.set_ce(1'b0, 1'b1);
      repeat (20) @(negedge clk);
      chk("block reset", 1'b0, brn);
      chk("crystal", 1'b0, xtal);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      close_out();
   end
   initial begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      t_power();
      t_full();
      t_lines();
      t_oob();
      t_speed();
      t_glitch();
      close_out();
   end
endmodule
